// file: sgc_frame_partner.sv
// Frame-bus controller model facing the stop/go block's frame pins.
// Assumes a 125 ns bit clock; captures the S/G slot and the D bits.
`timescale 1ns/1ps
`default_nettype none
module sgc_frame_partner #(
    parameter int FRAME_BITS = 32
) (
    input wire logic run,
    input wire logic accessBit,
    input wire logic frameDout,
    input wire logic frameDoutOe_n,
    output logic frameBitClk,
    output logic frameSync,
    output logic frameDin,
    output logic sgSeen,
    output logic dchanSeen,
    output int frameCnt
);
    // Frame generator: clock stands still between frames while run is low
    initial begin
        frameBitClk = 1'b0;
        frameSync = 1'b0;
        frameDin = 1'b1;
        sgSeen = 1'b1;
        dchanSeen = 1'b0;
        frameCnt = 0;
        forever begin
            if (!run) begin
                frameSync = 1'b0;
                frameDin = ~frameDin; // Idle line keeps moving
                #62.5;
            end else begin
                for (int b = 0; b < FRAME_BITS; b++) begin
                    frameSync = (b == 0);
                    if (b == 0) begin
                        frameCnt++;
                    end
                    // Access bit only in its slot, inverse elsewhere
                    frameDin = (b == 27) ? accessBit : ~accessBit;
                    #60;
                    // Slot values settled by the end of the bit
                    if (b == 28 && !frameDoutOe_n) begin
                        sgSeen = frameDout;
                    end
                    if (b == 25) begin
                        dchanSeen = !frameDoutOe_n && !frameDout;
                    end
                    #2.5 frameBitClk = 1'b1;
                    #62.5 frameBitClk = 1'b0;
                end
            end
        end
    end
endmodule // sgc_frame_partner
`default_nettype wire

// file: sgc_pkg.sv
// Constants shared by the stop/go bit controller and its timer.
// Assumes a 100 MHz system clock; all counts derive from that rate.
package sgc_pkg;
    // System clock rate
    localparam int unsigned CLK_MHZ = 100;
    localparam longint unsigned CLK_HZ = 64'd100_000_000;
    // Embedded operations codes
    localparam logic [7:0] EOC_STOP = 8'h25;
    localparam logic [7:0] EOC_GO = 8'h27;
    // Frame-bus bit positions, counted from the frame sync
    localparam logic [7:0] SG_BIT_POS = 8'd27;
    localparam logic [7:0] BAC_BIT_POS = 8'd27;
    localparam logic [7:0] DCH_BIT_LO = 8'd24;
    localparam logic [7:0] DCH_BIT_HI = 8'd25;
    // Timed stop window length in frames
    localparam logic [2:0] STOP_WINDOW_FRAMES = 3'd4;
    // Short hold timer, microseconds and cycles
    localparam int unsigned SHORT_HOLD_US = 500;
    localparam logic [31:0] SHORT_HOLD_CYC = 32'(SHORT_HOLD_US * CLK_MHZ);
    // EOC delay timer bounds, microseconds and cycles
    localparam int unsigned EOC_DELAY_MIN_US = 7500;
    localparam int unsigned EOC_DELAY_MAX_US = 15000;
    localparam logic [31:0] EOC_DELAY_MIN_CYC = 32'(EOC_DELAY_MIN_US * CLK_MHZ);
    localparam logic [31:0] EOC_DELAY_MAX_CYC = 32'(EOC_DELAY_MAX_US * CLK_MHZ);
    // Activation retry period, seconds and cycles
    localparam longint unsigned RETRY_S = 64'd15;
    localparam logic [31:0] RETRY_CYC = 32'(RETRY_S * CLK_HZ);
    // Reset values
    localparam logic SG_RST = 1'b0;
    localparam logic DOUT_OE_N_RST = 1'b1;
    // Controller states
    typedef enum logic [2:0] {
        SGC_IDLE, SGC_STOP_DELAY, SGC_TIMED, SGC_LATCHED, SGC_GO_DELAY
    } sgc_state_e;
endpackage

// file: sgc_timer.sv
// One-shot down-counting timer with load value and expiry pulse.
// Assumes start and load come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sgc_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic stop,
    input wire logic [31:0] loadVal,
    output logic running,
    output logic expired
);
    logic [31:0] count_r;

    // Load on start, count down, pulse on reaching zero
    always_ff @(posedge clk) begin
        if (rst || stop) begin
            count_r <= 32'h0000_0000;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (start) begin
            count_r <= loadVal;
            running <= 1'b1;
            expired <= 1'b0;
        end else if (running) begin
            count_r <= count_r - 32'h0000_0001;
            expired <= (count_r == 32'h0000_0001);
            running <= (count_r != 32'h0000_0001);
        end else begin
            expired <= 1'b0;
        end
    end
endmodule // sgc_timer
`default_nettype wire

// file: sgc_top.sv
// Stop/go bit controller for the terminal-side frame bus.
// Assumes frame clock, sync and data arrive from pins, config from logic.
// Functional notes
// - Static modes: level clear gives 0, else 1
// - Level+polarity: latch on stop/go, access bit drives
// - Window mode: stop gives 1 for four frames
// - Window inverted: stop gives 0 for four frames
// - Window+level: latch stop/go, access bit ignored
// - All set: latch, access bit drives S/G, D
// - Polarity clear after reset; set inverts pulse
// - Code 25h is the stop event
// - Code 27h is the go event
// - Short hold timer of 500 us
// - EOC delay timer, 7.5 to 15 ms
// - Access bit sampled at bit 27, input
// - S/G sent at bit 27, output
// - D-force drives upstream D bits low
// - Events accepted only while receiver synchronized
// - Register control only in host, terminal mode
// - S/G status also on dedicated pin
// - State six frame-bus value undefined
// - Auto mode retries activation every 15 s
// - Reset waits for frame clocks in some modes
`timescale 1ns/1ps
`default_nettype none
module sgc_top #(
    parameter logic [31:0] SHORT_HOLD_CYCLES = sgc_pkg::SHORT_HOLD_CYC,
    parameter logic [31:0] DELAY_MIN_CYCLES = sgc_pkg::EOC_DELAY_MIN_CYC,
    parameter logic [31:0] DELAY_MAX_CYCLES = sgc_pkg::EOC_DELAY_MAX_CYC,
    parameter logic [31:0] RETRY_CYCLES = sgc_pkg::RETRY_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic frameBitClk,
    input wire logic frameSync,
    input wire logic frameDin,
    input wire logic hostPortSelect,
    input wire logic subscriberEnd,
    input wire logic resetPin_n,
    input wire logic stopWindowMode,
    input wire logic stopGoLevel,
    input wire logic stopGoPolarity,
    input wire logic softPowerOn,
    input wire logic receiverSynced,
    input wire logic [7:0] eocCode,
    input wire logic eocValid,
    input wire logic eocLatePos,
    input wire logic ntAutoMode,
    input wire logic ltReady,
    input wire logic ntPbxOrLtMode,
    output logic frameDout,
    output logic frameDoutOe_n,
    output logic stopGoPin,
    output logic dchanForceZero,
    output logic activationStart
);
    import sgc_pkg::*;

    logic [5:0] sync1_r, sync2_r;
    logic dclPrev_r, fscPrev_r, dclRise, fscRise, dinInt, regCtl;
    logic [7:0] bitCnt_r, bitNow;
    logic fscSeen_r, bacBit_r, rstReq_r, coreRst;
    sgc_state_e state_r, state_nxt;
    logic [2:0] frameCnt_r;
    logic latched_r, timedActive, sgVal, dForce, isStop, isGo;
    logic tdStart, tdRun, tdExp;
    logic t1Start, t1Run, t1Exp;
    logic rtStart, rtRun, rtExp;
    logic autoDone_r, autoFirst_r;

    // Two-flop synchronisers for every pin input
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_r <= 6'h0F; // Idle levels: bit clock and sync low, no false edge
            sync2_r <= 6'h0F;
        end else begin
            sync1_r <= {frameBitClk, frameSync, frameDin, hostPortSelect,
                        subscriberEnd, resetPin_n};
            sync2_r <= sync1_r;
        end
    end

    // Edge history of the synchronised clock and sync
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dclPrev_r <= 1'b0;
            fscPrev_r <= 1'b0;
        end else begin
            dclPrev_r <= sync2_r[5];
            fscPrev_r <= sync2_r[4];
        end
    end

    assign dclRise = sync2_r[5] && !dclPrev_r;
    assign fscRise = sync2_r[4] && !fscPrev_r;
    // Soft power-on gates internal data in network-end mode
    assign dinInt = (!sync2_r[1] && !softPowerOn) ? 1'b0 : sync2_r[3];
    assign regCtl = sync2_r[2] && sync2_r[1];

    // Pin reset held until frame clocks appear where required
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rstReq_r <= 1'b0;
        end else if (!sync2_r[0]) begin
            rstReq_r <= rstReq_r || !ntPbxOrLtMode || dclRise; // Holds once started
        end else begin
            rstReq_r <= 1'b0;
        end
    end

    assign coreRst = sys_rst || rstReq_r;

    // Bit counter restarted by the frame sync
    assign bitNow = fscSeen_r ? 8'h00 : bitCnt_r + 8'h01; // Index of the bit now rising
    always_ff @(posedge clk) begin
        if (coreRst) begin
            bitCnt_r <= 8'h00;
            fscSeen_r <= 1'b0;
        end else if (dclRise) begin
            bitCnt_r <= bitNow;
            fscSeen_r <= fscRise;
        end else if (fscRise) begin
            fscSeen_r <= 1'b1;
        end
    end

    // Access bit capture from the input stream
    always_ff @(posedge clk) begin
        if (coreRst) begin
            bacBit_r <= 1'b0;
        end else if (dclRise && bitNow == BAC_BIT_POS) begin
            bacBit_r <= dinInt;
        end
    end

    // Event decode, only with a synchronised receiver
    assign isStop = eocValid && receiverSynced && eocCode == EOC_STOP;
    assign isGo = eocValid && receiverSynced && eocCode == EOC_GO;

    // Timer starts
    assign tdStart = (state_r == SGC_IDLE) && isStop && regCtl && stopWindowMode;
    assign t1Start = (state_r == SGC_LATCHED) && isGo;

    // Delay before a stop window, length set by EOC position
    sgc_timer u_delayTimer (
        .clk(clk),
        .rst(coreRst),
        .start(tdStart),
        .stop(1'b0),
        .loadVal(eocLatePos ? DELAY_MAX_CYCLES : DELAY_MIN_CYCLES),
        .running(tdRun),
        .expired(tdExp)
    );

    // Short hold before a latched stop releases
    sgc_timer u_holdTimer (
        .clk(clk),
        .rst(coreRst),
        .start(t1Start),
        .stop(1'b0),
        .loadVal(SHORT_HOLD_CYCLES),
        .running(t1Run),
        .expired(t1Exp)
    );

    // Activation retry period
    sgc_timer u_retryTimer (
        .clk(clk),
        .rst(coreRst),
        .start(rtStart),
        .stop(1'b0),
        .loadVal(RETRY_CYCLES),
        .running(rtRun),
        .expired(rtExp)
    );

    // Next state of the controller
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SGC_IDLE: begin
                if (regCtl && isStop && stopGoLevel) begin
                    state_nxt = SGC_LATCHED;
                end else if (tdStart) begin
                    state_nxt = SGC_STOP_DELAY;
                end
            end
            SGC_STOP_DELAY: begin
                if (tdExp) begin
                    state_nxt = SGC_TIMED;
                end
            end
            SGC_TIMED: begin
                if (frameCnt_r == STOP_WINDOW_FRAMES) begin
                    state_nxt = SGC_IDLE;
                end
            end
            SGC_LATCHED: begin
                if (t1Start) begin
                    state_nxt = SGC_GO_DELAY;
                end
            end
            SGC_GO_DELAY: begin
                if (isStop) begin
                    state_nxt = SGC_LATCHED;
                end else if (t1Exp) begin
                    state_nxt = SGC_IDLE;
                end
            end
            default: begin
                state_nxt = SGC_IDLE;
            end
        endcase
        if (!regCtl || !receiverSynced) begin
            state_nxt = SGC_IDLE;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (coreRst) begin
            state_r <= SGC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Frame counter for the stop window
    always_ff @(posedge clk) begin
        if (coreRst || state_r != SGC_TIMED) begin
            frameCnt_r <= 3'h0;
        end else if (fscRise) begin
            frameCnt_r <= frameCnt_r + 3'h1;
        end
    end

    assign latched_r = (state_r == SGC_LATCHED) || (state_r == SGC_GO_DELAY);
    assign timedActive = (state_r == SGC_TIMED);

    // S/G value and D-force from mode bits
    always_comb begin
        sgVal = 1'b0;
        dForce = 1'b0;
        if (!regCtl) begin
            sgVal = 1'b0;
        end else if (!stopWindowMode && !stopGoLevel) begin
            sgVal = 1'b0;
        end else if (!stopWindowMode && !stopGoPolarity) begin
            sgVal = 1'b1;
        end else if (!stopWindowMode) begin
            sgVal = latched_r || bacBit_r;
        end else if (!stopGoLevel) begin
            sgVal = timedActive ^ stopGoPolarity;
        end else if (!stopGoPolarity) begin
            sgVal = latched_r;
        end else begin
            sgVal = latched_r || bacBit_r;
            dForce = latched_r || bacBit_r;
        end
    end

    // Status pin and D-force registers
    always_ff @(posedge clk) begin
        if (coreRst) begin
            stopGoPin <= SG_RST;
            dchanForceZero <= 1'b0;
        end else begin
            stopGoPin <= sgVal; // Pin follows sgVal every cycle; the frame slot takes it only at bit 27
            dchanForceZero <= dForce;
        end
    end

    // Output stream: S/G bit and forced D bits
    always_ff @(posedge clk) begin
        if (coreRst) begin
            frameDout <= 1'b1;
            frameDoutOe_n <= DOUT_OE_N_RST;
        end else if (dclRise) begin
            if (bitNow == SG_BIT_POS) begin
                frameDout <= sgVal;
                frameDoutOe_n <= 1'b0;
            end else if (dForce && bitNow >= DCH_BIT_LO && bitNow <= DCH_BIT_HI) begin
                frameDout <= 1'b0;
                frameDoutOe_n <= 1'b0;
            end else begin
                frameDout <= 1'b1;
                frameDoutOe_n <= 1'b1;
            end
        end
    end

    // Activation attempts in auto mode after reset
    assign rtStart = ntAutoMode && !autoDone_r && (autoFirst_r || rtExp) && !ltReady;

    always_ff @(posedge clk) begin
        if (coreRst) begin
            autoDone_r <= 1'b0;
            autoFirst_r <= 1'b1;
            activationStart <= 1'b0;
        end else begin
            activationStart <= 1'b0;
            if (ntAutoMode && !autoDone_r && (autoFirst_r || rtExp)) begin
                activationStart <= 1'b1;
                autoFirst_r <= 1'b0;
                autoDone_r <= ltReady;
            end
        end
    end

    // Window ends once four frame syncs have been counted from its start
    property p_window_len;
        @(posedge clk) disable iff (coreRst)
        (state_r == SGC_TIMED && frameCnt_r == STOP_WINDOW_FRAMES) |=> state_r == SGC_IDLE;
    endproperty
    a_window_len: assert property (p_window_len) else $error("window overran");
    property p_static_zero;
        @(posedge clk) disable iff (coreRst)
        (regCtl && !stopWindowMode && !stopGoLevel) |=> !stopGoPin;
    endproperty
    a_static_zero: assert property (p_static_zero) else $error("static zero wrong");
    property p_static_one;
        @(posedge clk) disable iff (coreRst)
        (regCtl && !stopWindowMode && stopGoLevel && !stopGoPolarity) |=> stopGoPin;
    endproperty
    a_static_one: assert property (p_static_one) else $error("static one wrong");
    property p_stop_latch;
        @(posedge clk) disable iff (coreRst)
        (state_r == SGC_IDLE && regCtl && receiverSynced && isStop && stopGoLevel)
            |=> state_r == SGC_LATCHED;
    endproperty
    a_stop_latch: assert property (p_stop_latch) else $error("stop not latched");
    property p_timed_pol;
        @(posedge clk) disable iff (coreRst)
        (regCtl && stopWindowMode && !stopGoLevel && timedActive) |=> stopGoPin == !$past(stopGoPolarity);
    endproperty
    a_timed_pol: assert property (p_timed_pol) else $error("pulse polarity wrong");

    property p_unsync_idle;
        @(posedge clk) disable iff (coreRst)
        !receiverSynced |=> state_r == SGC_IDLE;
    endproperty
    a_unsync_idle: assert property (p_unsync_idle) else $error("active while unsynced");

    property p_mode_gate;
        @(posedge clk) disable iff (coreRst)
        !regCtl |=> (!stopGoPin && !dchanForceZero);
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("controlled outside mode");

    property p_go_release;
        @(posedge clk) disable iff (coreRst)
        (state_r == SGC_GO_DELAY && t1Exp && !isStop && regCtl && receiverSynced)
            |=> state_r == SGC_IDLE;
    endproperty
    a_go_release: assert property (p_go_release) else $error("go not released");

    property p_dforce_mode;
        @(posedge clk) disable iff (coreRst)
        dchanForceZero |-> $past(regCtl && stopWindowMode && stopGoLevel && stopGoPolarity);
    endproperty
    a_dforce_mode: assert property (p_dforce_mode) else $error("D forced in wrong mode");
endmodule // sgc_top
`default_nettype wire

// file: sgc_top_tb.sv
// Self-checking bench for the stop/go bit controller.
// Assumes the frame partner model and shortened timer parameters.
`timescale 1ns/1ps
`default_nettype none
module sgc_top_tb;
    import sgc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hostPortSelect = 1'b1;
    logic subscriberEnd = 1'b1;
    logic resetPin_n = 1'b1;
    logic stopWindowMode = 1'b0;
    logic stopGoLevel = 1'b0;
    logic stopGoPolarity = 1'b0;
    logic softPowerOn = 1'b1;
    logic receiverSynced = 1'b1;
    logic [7:0] eocCode = 8'h00;
    logic eocValid = 1'b0;
    logic eocLatePos = 1'b0;
    logic ntAutoMode = 1'b0;
    logic ltReady = 1'b0;
    logic ntPbxOrLtMode = 1'b0;
    logic run = 1'b1;
    logic accessBit = 1'b0;
    logic frameBitClk, frameSync, frameDin, frameDout, frameDoutOe_n;
    logic stopGoPin, dchanForceZero, activationStart, sgSeen, dchanSeen;
    int frameCnt;
    int errorCnt = 0;
    int checks = 0;
    int cycles = 0;

    // System clock, 100 MHz
    always #5 clk = ~clk;

    sgc_top #(
        .SHORT_HOLD_CYCLES(32'd20), .DELAY_MIN_CYCLES(32'd30),
        .DELAY_MAX_CYCLES(32'd60), .RETRY_CYCLES(32'd100)
    ) sgc_top_inst (
        .clk(clk), .sys_rst(sys_rst), .frameBitClk(frameBitClk), .frameSync(frameSync),
        .frameDin(frameDin), .hostPortSelect(hostPortSelect), .subscriberEnd(subscriberEnd),
        .resetPin_n(resetPin_n), .stopWindowMode(stopWindowMode), .stopGoLevel(stopGoLevel),
        .stopGoPolarity(stopGoPolarity), .softPowerOn(softPowerOn),
        .receiverSynced(receiverSynced), .eocCode(eocCode), .eocValid(eocValid),
        .eocLatePos(eocLatePos), .ntAutoMode(ntAutoMode), .ltReady(ltReady),
        .ntPbxOrLtMode(ntPbxOrLtMode), .frameDout(frameDout), .frameDoutOe_n(frameDoutOe_n),
        .stopGoPin(stopGoPin), .dchanForceZero(dchanForceZero),
        .activationStart(activationStart)
    );

    sgc_frame_partner sgc_frame_partner_inst (
        .run(run), .accessBit(accessBit), .frameDout(frameDout),
        .frameDoutOe_n(frameDoutOe_n), .frameBitClk(frameBitClk), .frameSync(frameSync),
        .frameDin(frameDin), .sgSeen(sgSeen), .dchanSeen(dchanSeen), .frameCnt(frameCnt)
    );

    // Compare one value and count it
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Summary and verdict
    task automatic endSim;
        $display("checks=%0d errors=%0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errorCnt++;
            endSim();
        end
    end

    // Mode bits, then let them settle
    task automatic setMode(input logic bs, input logic lvl, input logic pol);
        @(posedge clk);
        stopWindowMode <= bs;
        stopGoLevel <= lvl;
        stopGoPolarity <= pol;
        repeat (4) @(posedge clk);
    endtask

    // One received code, one cycle wide
    task automatic sendEoc(input logic [7:0] code);
        @(posedge clk);
        eocCode <= code;
        eocValid <= 1'b1;
        @(posedge clk);
        eocValid <= 1'b0;
    endtask

    // Pin value after n edges, once updates have landed
    task automatic pinIs(input int n, input logic exp);
        repeat (n) @(posedge clk);
        #1;
        check(stopGoPin, exp);
    endtask

    task automatic waitFrames(input int n);
        int f;
        f = frameCnt;
        wait (frameCnt >= f + n);
    endtask

    // Count activation pulses over n cycles
    task automatic countPulses(input int n, input int exp);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (activationStart === 1'b1) begin
                c++;
            end
        end
        check(c[7:0], exp[7:0]);
    endtask

    task automatic doReset;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        // Static levels
        setMode(1'b0, 1'b0, 1'b0);
        pinIs(1, 1'b0);
        waitFrames(2);
        check(sgSeen, 1'b0);
        setMode(1'b0, 1'b1, 1'b0);
        pinIs(1, 1'b1);
        waitFrames(2);
        check(sgSeen, 1'b1);
        setMode(1'b0, 1'b0, 1'b1);
        pinIs(1, 1'b0);
        // Latched with access bit
        setMode(1'b0, 1'b1, 1'b1);
        pinIs(1, 1'b0);
        sendEoc(8'h26);
        pinIs(3, 1'b0);
        sendEoc(EOC_STOP);
        pinIs(2, 1'b1);
        waitFrames(2);
        check(sgSeen, 1'b1);
        sendEoc(EOC_GO);
        pinIs(5, 1'b1);
        pinIs(25, 1'b0);
        @(posedge clk) accessBit <= 1'b1;
        waitFrames(2);
        check(stopGoPin, 1'b1);
        check(dchanForceZero, 1'b0);
        @(posedge clk) accessBit <= 1'b0;
        // Timed window, early frame position
        setMode(1'b1, 1'b0, 1'b0);
        pinIs(1, 1'b0);
        sendEoc(EOC_STOP);
        pinIs(20, 1'b0);
        pinIs(25, 1'b1);
        waitFrames(2);
        check(stopGoPin, 1'b1);
        waitFrames(4);
        check(stopGoPin, 1'b0);
        // Inverted window, late frame position
        @(posedge clk) eocLatePos <= 1'b1;
        setMode(1'b1, 1'b0, 1'b1);
        pinIs(1, 1'b1);
        sendEoc(EOC_STOP);
        pinIs(45, 1'b1);
        pinIs(30, 1'b0);
        waitFrames(2);
        check(sgSeen, 1'b0);
        waitFrames(4);
        check(stopGoPin, 1'b1);
        // Latched, access bit ignored
        @(posedge clk) accessBit <= 1'b1;
        setMode(1'b1, 1'b1, 1'b0);
        waitFrames(2);
        check(stopGoPin, 1'b0);
        sendEoc(EOC_STOP);
        pinIs(2, 1'b1);
        sendEoc(EOC_GO);
        pinIs(30, 1'b0);
        // All set: access bit drives S/G and D
        setMode(1'b1, 1'b1, 1'b1);
        waitFrames(2);
        check(stopGoPin, 1'b1);
        check(dchanForceZero, 1'b1);
        check(dchanSeen, 1'b1);
        @(posedge clk) accessBit <= 1'b0;
        waitFrames(2);
        check(dchanForceZero, 1'b0);
        check(stopGoPin, 1'b0);
        sendEoc(EOC_STOP);
        pinIs(2, 1'b1);
        sendEoc(EOC_GO);
        pinIs(30, 1'b0);
        // Events refused while receiver unsynced
        @(posedge clk) receiverSynced <= 1'b0;
        setMode(1'b1, 1'b1, 1'b0);
        sendEoc(EOC_STOP);
        pinIs(5, 1'b0);
        @(posedge clk) receiverSynced <= 1'b1;
        // Outside host or terminal mode
        setMode(1'b0, 1'b1, 1'b0);
        @(posedge clk) hostPortSelect <= 1'b0;
        pinIs(6, 1'b0);
        @(posedge clk) hostPortSelect <= 1'b1;
        @(posedge clk) subscriberEnd <= 1'b0;
        pinIs(6, 1'b0);
        @(posedge clk) subscriberEnd <= 1'b1;
        pinIs(6, 1'b1);
        // Pin reset waits for frame clocks
        @(posedge clk) ntPbxOrLtMode <= 1'b1;
        @(posedge clk) run <= 1'b0;
        repeat (500) @(posedge clk);
        resetPin_n <= 1'b0;
        pinIs(20, 1'b1);
        @(posedge clk) run <= 1'b1;
        pinIs(100, 1'b0);
        @(posedge clk) resetPin_n <= 1'b1;
        pinIs(20, 1'b1);
        @(posedge clk) ntPbxOrLtMode <= 1'b0;
        @(posedge clk) resetPin_n <= 1'b0;
        pinIs(6, 1'b0);
        @(posedge clk) resetPin_n <= 1'b1;
        // Auto activation retries
        @(posedge clk) softPowerOn <= 1'b0; // Soft power-on low; internal data not gated here, as subscriberEnd is high
        @(posedge clk) ntAutoMode <= 1'b1;
        doReset();
        countPulses(350, 4);
        @(posedge clk) ltReady <= 1'b1;
        countPulses(450, 1);
        doReset();
        countPulses(350, 1);
        @(posedge clk) softPowerOn <= 1'b1; // Host releases data with activation
        endSim();
    end
endmodule // sgc_top_tb
`default_nettype wire
